/* pkg/intc_pkg.sv */
package intc_pkg;

  // ==========================================================
  // Sizes and vector address
  localparam int NUM_SRC = 4;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 4;
  localparam int NUM_EV = 3;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 12'h002;

  // ==========================================================
  // Source positions in the flag and mask fields
  localparam int SRC_EXT = 0;
  localparam int SRC_RX_SYNC = 1;
  localparam int SRC_TX_SYNC = 2;
  localparam int SRC_FRAME_EV = 3;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] EVT_OFS = 8'h08;
  localparam logic [7:0] EVT_MASK_OFS = 8'h0c;
  localparam logic [7:0] MODE_OFS = 8'h10;

  // ==========================================================
  // Field positions
  localparam int FLAG_LSB = 0;
  localparam int MASK_LSB = 4;
  localparam int ST_GID = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_DEPTH_LSB = 4;
  localparam int ST_TOP_LSB = 16;
  localparam int EV_ACK = 0;
  localparam int EV_OVF = 1;
  localparam int EV_UNF = 2;
  localparam int MODE_COPROC = 0;

  // ==========================================================
  // Values after reset
  localparam logic [NUM_SRC-1:0] MASK_RST = 4'h0;
  localparam logic GID_RST = 1'b1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic fetch_boundary;
    logic enable_insn;
    logic push;
    logic pop;
    logic [PC_W-1:0] pc;
  } seq_req_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic flag;
  } flag_state_t;

  typedef struct packed {
    logic [NUM_SRC-1:0] mask;
    logic gid;
    logic latch;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [2:0] depth;
    logic [NUM_EV-1:0] evt;
    logic [NUM_EV-1:0] evt_mask;
    logic coproc;
    logic wb_ack;
    logic [31:0] rdata;
    logic pc_load;
  } ctl_state_t;

endpackage

/* hw/src_flag.sv */
`timescale 1ns/1ps
module src_flag import intc_pkg::*; #(
  parameter bit PERSIST = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_src,
  input wire logic i_clear,
  output logic o_flag
);

  flag_state_t s_r;
  flag_state_t s_nxt;
  logic set;

  // ==========================================================
  // Sync and flag
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = i_src;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    // Level sources re-set while active, so a clear cannot stick
    set = PERSIST ? s_r.sync2 : (s_r.sync2 & ~s_r.sync3);
    s_nxt.flag = set | (s_r.flag & ~i_clear);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_flag = s_r.flag;

  // ==========================================================
  // Checks
  property p_src_sets;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (!i_src ##1 i_src [*3]) |=> o_flag;
  endproperty
  a_src_sets: assert property (p_src_sets) else $error("Source did not set flag");

  property p_clear;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_clear && !set) |=> !o_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("Flag clear had no effect");

  property p_zero_write;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (o_flag && !i_clear) |=> o_flag;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("Flag dropped without clear");

  property p_persist;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (PERSIST && i_src) [*4] |=> o_flag;
  endproperty
  a_persist: assert property (p_persist) else $error("Active level lost its flag");

endmodule

/* hw/four_source_interrupt_control.sv */
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module four_source_interrupt_control import intc_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wb_req_t i_wb,
  output wb_rsp_t o_wb,
  input seq_req_t i_seq,
  input wire logic i_external_interrupt_line,
  input wire logic i_receive_frame_sync,
  input wire logic i_transmit_frame_sync,
  input wire logic i_serial_frame_event,
  input wire logic i_branch_test_input,
  input wire logic i_coproc_interrupt,
  input wire logic i_coproc_branch_test,
  output logic o_branch_test,
  output logic o_int_request,
  output logic o_int_ack,
  output logic o_pc_load,
  output logic [PC_W-1:0] o_pc_vector,
  output logic [PC_W-1:0] o_stack_top,
  output logic o_irq
);

  ctl_state_t s_r;
  ctl_state_t s_nxt;
  logic [NUM_SRC-1:0] src;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] clr_flags;
  logic access;
  logic wr;
  logic take;
  logic pending;
  logic [NUM_EV-1:0] ev_set;
  logic [31:0] rd;

  // ==========================================================
  // Source selection
  // Coprocessor mode takes the line from the port, not the pin
  always_comb begin
    src = '0;
    src[SRC_EXT] = s_r.coproc ? i_coproc_interrupt : i_external_interrupt_line;
    src[SRC_RX_SYNC] = i_receive_frame_sync;
    src[SRC_TX_SYNC] = i_transmit_frame_sync;
    src[SRC_FRAME_EV] = i_serial_frame_event;
  end

  assign o_branch_test = s_r.coproc ? i_coproc_branch_test : i_branch_test_input;

  // ==========================================================
  // Per-source flags
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_flag
      src_flag #(
        .PERSIST(g == SRC_EXT)
      ) u_flag (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_src(src[g]),
        .i_clear(clr_flags[g]),
        .o_flag(flags[g])
      );
    end
  endgenerate

  // ==========================================================
  // Control logic
  assign access = i_wb.cyc & i_wb.stb & ~s_r.wb_ack;
  assign wr = access & i_wb.we & i_wb.sel[0];
  assign pending = |(flags & s_r.mask);
  assign take = s_r.latch & ~s_r.gid & i_seq.fetch_boundary;

  always_comb begin
    rd = '0;
    case (i_wb.adr)
      CTRL_OFS: begin
        rd[FLAG_LSB +: NUM_SRC] = flags;
        rd[MASK_LSB +: NUM_SRC] = s_r.mask;
      end
      STAT_OFS: begin
        rd[ST_GID] = s_r.gid;
        rd[ST_LATCH] = s_r.latch;
        rd[ST_DEPTH_LSB +: 3] = s_r.depth;
        rd[ST_TOP_LSB +: PC_W] = s_r.stack[0];
      end
      EVT_OFS: begin
        rd[NUM_EV-1:0] = s_r.evt;
      end
      EVT_MASK_OFS: begin
        rd[NUM_EV-1:0] = s_r.evt_mask;
      end
      MODE_OFS: begin
        rd[MODE_COPROC] = s_r.coproc;
      end
      default: begin
        rd = '0;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    clr_flags = '0;
    ev_set = '0;
    s_nxt.wb_ack = access;
    s_nxt.pc_load = take;
    if (access) begin
      s_nxt.rdata = rd;
    end
    if (wr) begin
      case (i_wb.adr)
        CTRL_OFS: begin
          s_nxt.mask = i_wb.dat[MASK_LSB +: NUM_SRC];
          clr_flags = i_wb.dat[FLAG_LSB +: NUM_SRC];
        end
        EVT_OFS: begin
          s_nxt.evt = s_r.evt & ~i_wb.dat[NUM_EV-1:0];
        end
        EVT_MASK_OFS: begin
          s_nxt.evt_mask = i_wb.dat[NUM_EV-1:0];
        end
        MODE_OFS: begin
          s_nxt.coproc = i_wb.dat[MODE_COPROC];
        end
        default: begin
          s_nxt.coproc = s_r.coproc;
        end
      endcase
    end
    // Master latch: acknowledge clears it, a waiting source re-arms it
    if (take) begin
      s_nxt.latch = 1'b0;
    end else if (pending) begin
      s_nxt.latch = 1'b1;
    end
    if (i_seq.enable_insn) begin
      s_nxt.gid = 1'b0;
    end
    if (take) begin
      s_nxt.gid = 1'b1;
    end
    // Stack: the deepest entry falls off on overflow
    if (take || i_seq.push) begin
      s_nxt.stack = {s_r.stack[STACK_DEPTH-2:0], i_seq.pc};
      if (s_r.depth == 3'(STACK_DEPTH)) begin
        ev_set[EV_OVF] = 1'b1;
      end else begin
        s_nxt.depth = s_r.depth + 3'h1;
      end
    end else if (i_seq.pop) begin
      s_nxt.stack = {s_r.stack[STACK_DEPTH-1], s_r.stack[STACK_DEPTH-1:1]};
      if (s_r.depth == 3'h0) begin
        ev_set[EV_UNF] = 1'b1;
      end else begin
        s_nxt.depth = s_r.depth - 3'h1;
      end
    end
    ev_set[EV_ACK] = take;
    // Hardware set beats a same-cycle software clear
    s_nxt.evt = s_nxt.evt | ev_set;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
      s_r.mask <= MASK_RST;
      s_r.gid <= GID_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign o_wb.ack = s_r.wb_ack;
  assign o_wb.dat = s_r.rdata;
  assign o_int_request = s_r.latch & ~s_r.gid;
  assign o_int_ack = take;
  assign o_pc_load = s_r.pc_load;
  assign o_pc_vector = VECTOR_ADDR;
  assign o_stack_top = s_r.stack[0];
  assign o_irq = |(s_r.evt & s_r.evt_mask);

  // ==========================================================
  // Checks
  property p_mask_write;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (wr && i_wb.adr == CTRL_OFS) |=> (s_r.mask == $past(i_wb.dat[7:4]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("Mask write lost");

  property p_flag_read;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (access && !i_wb.we && i_wb.adr == CTRL_OFS) |=> (o_wb.dat[3:0] == $past(flags));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("Flag read mismatch");

  property p_latch_cause;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(s_r.latch) |-> $past(pending);
  endproperty
  a_latch_cause: assert property (p_latch_cause) else $error("Latch set with no source");

  property p_enable;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_seq.enable_insn && !take) |=> !s_r.gid;
  endproperty
  a_enable: assert property (p_enable) else $error("Enable did not clear disable");

  property p_latch_set;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (pending && !take) |=> s_r.latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("Request did not set latch");

  property p_ack_seq;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    take |=> (!s_r.latch && s_r.gid && !o_int_request);
  endproperty
  a_ack_seq: assert property (p_ack_seq) else $error("Acknowledge state wrong");

  property p_push;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    take |=> (o_stack_top == $past(i_seq.pc) && s_r.stack[1] == $past(s_r.stack[0]));
  endproperty
  a_push: assert property (p_push) else $error("Return address not pushed");

  property p_vector;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    take |=> (o_pc_load && o_pc_vector == 12'h002) ##1 !o_pc_load;
  endproperty
  a_vector: assert property (p_vector) else $error("Vector load wrong");

  property p_coproc;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    s_r.coproc |-> (src[SRC_EXT] == i_coproc_interrupt && o_branch_test == i_coproc_branch_test);
  endproperty
  a_coproc: assert property (p_coproc) else $error("Coprocessor routing wrong");

  property p_depth;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (take && s_r.depth < 3'h4) |=> (s_r.depth == $past(s_r.depth) + 3'h1) && s_r.depth <= 3'h4;
  endproperty
  a_depth: assert property (p_depth) else $error("Stack depth wrong");

  property p_gated;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (o_int_ack |-> !s_r.gid) and ((!pending && !s_r.latch) |=> !s_r.latch);
  endproperty
  a_gated: assert property (p_gated) else $error("Masked or disabled request taken");

  property p_pc_load_pulse;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    o_pc_load |=> !o_pc_load;
  endproperty
  a_pc_load_pulse: assert property (p_pc_load_pulse) else $error("Vector load too long");

  property p_pc_load_cause;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    o_pc_load |-> $past(take);
  endproperty
  a_pc_load_cause: assert property (p_pc_load_cause) else $error("Vector load with no ack");

  property p_ack_needs_latch;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    o_int_ack |-> (s_r.latch && i_seq.fetch_boundary);
  endproperty
  a_ack_needs_latch: assert property (p_ack_needs_latch) else $error("Ack with no request");

  property p_disable_hold;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (s_r.gid && !i_seq.enable_insn) |=> s_r.gid;
  endproperty
  a_disable_hold: assert property (p_disable_hold) else $error("Disable bit dropped");

  property p_latch_hold;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (s_r.latch && !take) |=> s_r.latch;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Latch lost before ack");

  property p_ack_event;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    take |=> s_r.evt[EV_ACK];
  endproperty
  a_ack_event: assert property (p_ack_event) else $error("Ack event not recorded");

  property p_overflow;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    ((take || i_seq.push) && s_r.depth == 3'h4) |=> (s_r.evt[EV_OVF] && s_r.depth == 3'h4);
  endproperty
  a_overflow: assert property (p_overflow) else $error("Stack overflow wrong");

  property p_pop;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_seq.pop && !i_seq.push && !take && s_r.depth != 3'h0)
      |=> (s_r.depth == $past(s_r.depth) - 3'h1);
  endproperty
  a_pop: assert property (p_pop) else $error("Pop depth wrong");

  property p_underflow;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_seq.pop && !i_seq.push && !take && s_r.depth == 3'h0)
      |=> (s_r.evt[EV_UNF] && s_r.depth == 3'h0);
  endproperty
  a_underflow: assert property (p_underflow) else $error("Stack underflow wrong");

  property p_pin_route;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !s_r.coproc |-> (src[SRC_EXT] == i_external_interrupt_line
      && o_branch_test == i_branch_test_input);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("Pin routing wrong");

  property p_stat_read;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (access && !i_wb.we && i_wb.adr == STAT_OFS)
      |=> (o_wb.dat[0] == $past(s_r.gid) && o_wb.dat[1] == $past(s_r.latch));
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("Status read mismatch");

  property p_mask_read;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (access && !i_wb.we && i_wb.adr == CTRL_OFS) |=> (o_wb.dat[7:4] == $past(s_r.mask));
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("Mask read mismatch");

  property p_mask_hold;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !(wr && i_wb.adr == CTRL_OFS) |=> (s_r.mask == $past(s_r.mask));
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("Mask changed unasked");

endmodule

/* bench/src_model.sv */
`timescale 1ns/1ps
module src_model (
  input wire logic i_sys_clk,
  input wire logic i_coproc,
  input wire logic i_ext_on,
  input wire logic [2:0] i_pulse,
  output logic o_ext,
  output logic o_rx,
  output logic o_tx,
  output logic o_frame
);
  initial begin
    o_ext = 1'b0;
    {o_frame, o_tx, o_rx} = 3'h0;
  end
  // Port owns the external line in coprocessor mode, so the pin stays quiet
  always @(posedge i_sys_clk) begin
    o_ext <= i_ext_on & ~i_coproc;
    {o_frame, o_tx, o_rx} <= i_pulse;
  end
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import intc_pkg::*;
  logic clk, rstn, ext_on, coproc, bt, cbt, cint;
  logic ext, rx, tx, fr, btest, ireq, iack, pcl, irq;
  logic [2:0] pulse;
  logic [11:0] vec, top;
  logic [31:0] q;
  wb_req_t wb;
  wb_rsp_t rsp;
  seq_req_t seq;
  int bad_count, checked;

  four_source_interrupt_control four_source_interrupt_control_i (.i_sys_clk(clk),
    .i_rstn(rstn), .i_wb(wb), .o_wb(rsp), .i_seq(seq), .i_external_interrupt_line(ext),
    .i_receive_frame_sync(rx), .i_transmit_frame_sync(tx), .i_serial_frame_event(fr),
    .i_branch_test_input(bt), .i_coproc_interrupt(cint), .i_coproc_branch_test(cbt),
    .o_branch_test(btest), .o_int_request(ireq), .o_int_ack(iack), .o_pc_load(pcl),
    .o_pc_vector(vec), .o_stack_top(top), .o_irq(irq));
  src_model src_model_i (.i_sys_clk(clk), .i_coproc(coproc), .i_ext_on(ext_on),
    .i_pulse(pulse), .o_ext(ext), .o_rx(rx), .o_tx(tx), .o_frame(fr));

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Request stands until the edge that samples ack high; idle edge before the next
  task automatic wb_go(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb <= '{1'b1, 1'b1, w, a, 4'hf, d};
    @(posedge clk);
    while (rsp.ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      bad_count++;
      print_verdict();
    end
    q = rsp.dat;
    wb <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb_go(1'b0, a, 32'h0);
    chk("read data", e, q & m);
  endtask

  task automatic raise(input int s);
    @(posedge clk);
    if (s == 0) ext_on <= 1'b1;
    else pulse[s-1] <= 1'b1;
    @(posedge clk);
    ext_on <= 1'b0;
    pulse <= '0;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rstn, ext_on, coproc, bt, cbt, cint, pulse} = '0;
    wb = '0;
    seq = '0;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(CTRL_OFS, 32'hff, 32'h0);
    rd(STAT_OFS, 32'h73, 32'h1);
    rd(8'h14, 32'hffffffff, 32'h0);
    $display("reset test done");
    for (int s = 0; s < 4; s++) begin
      raise(s);
      repeat (6) @(posedge clk);
      rd(CTRL_OFS, 32'hff, 32'h1 << s);
      wb_go(1'b1, CTRL_OFS, 32'h0);
      rd(CTRL_OFS, 32'hff, 32'h1 << s);
      chk("int_request", 32'h0, 32'(ireq));
      wb_go(1'b1, CTRL_OFS, 32'h1 << s);
      rd(CTRL_OFS, 32'hff, 32'h0);
    end
    $display("source test done");
    wb_go(1'b1, CTRL_OFS, 32'hf0);
    raise(1);
    repeat (5) @(posedge clk);
    chk("int_request", 32'h0, 32'(ireq));
    seq.enable_insn <= 1'b1;
    @(posedge clk);
    seq.enable_insn <= 1'b0;
    @(negedge clk);
    chk("int_request", 32'h1, 32'(ireq));
    @(posedge clk);
    seq.pc <= 12'habc;
    seq.fetch_boundary <= 1'b1;
    @(negedge clk);
    chk("int_ack", 32'h1, 32'(iack));
    @(posedge clk);
    seq.fetch_boundary <= 1'b0;
    @(negedge clk);
    chk("pc_load", 32'h1, 32'(pcl));
    chk("pc_vector", 32'h2, 32'(vec));
    chk("stack_top", 32'habc, 32'(top));
    chk("int_request", 32'h0, 32'(ireq));
    @(negedge clk);
    chk("pc_load", 32'h0, 32'(pcl));
    rd(STAT_OFS, 32'h0fff0073, 32'h0abc0013);
    wb_go(1'b1, CTRL_OFS, 32'hf2);
    rd(EVT_OFS, 32'h1, 32'h1);
    wb_go(1'b1, EVT_MASK_OFS, 32'h1);
    @(negedge clk);
    chk("irq", 32'h1, 32'(irq));
    wb_go(1'b1, EVT_OFS, 32'h1);
    @(negedge clk);
    chk("irq", 32'h0, 32'(irq));
    $display("acknowledge test done");
    // Two pops from depth one reach underflow; five pushes reach overflow
    @(posedge clk);
    seq.pop <= 1'b1;
    repeat (2) @(posedge clk);
    seq.pop <= 1'b0;
    seq.push <= 1'b1;
    repeat (5) @(posedge clk);
    seq.push <= 1'b0;
    rd(EVT_OFS, 32'h6, 32'h6);
    rd(STAT_OFS, 32'h70, 32'h40);
    wb_go(1'b1, EVT_OFS, 32'h6);
    $display("stack test done");
    @(posedge clk);
    ext_on <= 1'b1;
    repeat (6) @(posedge clk);
    wb_go(1'b1, CTRL_OFS, 32'hf1);
    rd(CTRL_OFS, 32'h1, 32'h1);
    ext_on <= 1'b0;
    repeat (6) @(posedge clk);
    wb_go(1'b1, CTRL_OFS, 32'hf1);
    rd(CTRL_OFS, 32'hff, 32'hf0);
    $display("persistence test done");
    bt <= 1'b1;
    @(negedge clk);
    chk("branch_test", 32'h1, 32'(btest));
    wb_go(1'b1, MODE_OFS, 32'h1);
    coproc <= 1'b1;
    bt <= 1'b0;
    cbt <= 1'b1;
    cint <= 1'b1;
    @(negedge clk);
    chk("branch_test", 32'h1, 32'(btest));
    rd(MODE_OFS, 32'h1, 32'h1);
    rd(CTRL_OFS, 32'h1, 32'h1);
    $display("coprocessor test done");
    print_verdict();
  end
endmodule
